/* File: rtl/gpio_ports.sv */
// How it works
// - Each port has a write-only pull-up register, one bit per pin, set to enable and reset to 0 except port 0 pin 2.
// - Port 0 pin 2 is input-only without pull-up and its pull-up bit stays at one.
// - The open-drain register holds port 1 pin 0 at bit 0 and pin 1 at bit 1, reset to 0.
// - In open-drain mode a pin with its direction bit at one only sinks for a low and releases the line for a high; with it at zero the pin stays released.
// - Clearing open-drain returns the pin to its previous direction with no restore step.
// - Reading a port data register returns the current pin levels of that port.
// - Writing a port data register loads the output latches, which reset to zero.
// - A single-bit set or clear changes only the addressed latch bit.
// - Port 0 pin 2 data is read-only and reads one when external reset is selected.
// - Each pin has a direction bit, reset 0 except port 0 pin 2 which stays one, where 0 is input and 1 is output.
`timescale 1ns/10ps
`default_nettype none
module gpio_ports
  import gpio_pkg::*;
(
  // APB slave.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Configuration option.
  input  wire logic        ext_reset_sel,
  // Port pins, split into input, output and output enable.
  input  wire logic [7:0]  port0_in,
  input  wire logic [7:0]  port1_in,
  input  wire logic [7:0]  port2_in,
  input  wire logic [7:0]  port5_in,
  output logic [7:0]       port0_out,
  output logic [7:0]       port1_out,
  output logic [7:0]       port2_out,
  output logic [7:0]       port5_out,
  output logic [7:0]       port0_oe,
  output logic [7:0]       port1_oe,
  output logic [7:0]       port2_oe,
  output logic [7:0]       port5_oe,
  // Pull-up enables towards the pad cells.
  output logic [7:0]       port0_pullup,
  output logic [7:0]       port1_pullup,
  output logic [7:0]       port2_pullup,
  output logic [7:0]       port5_pullup
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [1:0] port_index(input logic [7:0] addr);
    port_index = (addr[2:0] == 3'h5) ? 2'd3 : addr[1:0];
  endfunction

  function automatic logic [7:0] port_mask(input logic [1:0] idx);
    case (idx)
      2'd0:    port_mask = GPIO_MASK_P0;
      2'd1:    port_mask = GPIO_MASK_P1;
      2'd2:    port_mask = GPIO_MASK_P2;
      default: port_mask = GPIO_MASK_P5;
    endcase
  endfunction

  // Register classes, decoded from the word index of the access.
  function automatic logic is_data_addr(input logic [7:0] addr);
    case (addr)
      GPIO_ADDR_PORT0_DATA, GPIO_ADDR_PORT1_DATA, GPIO_ADDR_PORT2_DATA,
      GPIO_ADDR_PORT5_DATA:
        is_data_addr = 1'b1;
      default:
        is_data_addr = 1'b0;
    endcase
  endfunction

  function automatic logic is_pullup_addr(input logic [7:0] addr);
    case (addr)
      GPIO_ADDR_PULLUP_P0, GPIO_ADDR_PULLUP_P1, GPIO_ADDR_PULLUP_P2,
      GPIO_ADDR_PULLUP_P5:
        is_pullup_addr = 1'b1;
      default:
        is_pullup_addr = 1'b0;
    endcase
  endfunction

  function automatic logic is_dir_addr(input logic [7:0] addr);
    case (addr)
      GPIO_ADDR_DIR_P0, GPIO_ADDR_DIR_P1, GPIO_ADDR_DIR_P2,
      GPIO_ADDR_DIR_P5:
        is_dir_addr = 1'b1;
      default:
        is_dir_addr = 1'b0;
    endcase
  endfunction

  function automatic logic is_mapped_addr(input logic [7:0] addr);
    is_mapped_addr = is_data_addr(addr) || is_pullup_addr(addr) || is_dir_addr(addr) ||
                     (addr == GPIO_ADDR_OD_CTRL) || (addr == GPIO_ADDR_BIT_OP);
  endfunction

  // A single-bit operation on a pin that the port lacks is dropped.
  function automatic logic bit_implemented(input logic [1:0] idx, input logic [2:0] pos);
    logic [7:0] mask;
    mask            = port_mask(idx);
    bit_implemented = mask[pos];
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] data_q   [4];
  logic [7:0] data_d   [4];
  logic [7:0] pullup_q [4];
  logic [7:0] pullup_d [4];
  logic [7:0] dir_q    [4];
  logic [7:0] dir_d    [4];
  logic [7:0] od_q;
  logic [7:0] od_d;
  logic [7:0] pin_in   [4];
  logic [7:0] wbyte;
  logic [7:0] word_addr;
  logic       wr_en;
  logic       addr_ok;
  logic [1:0] sel_port;
  logic [7:0] sel_mask;

  assign pin_in[0] = port0_in;
  assign pin_in[1] = port1_in;
  assign pin_in[2] = port2_in;
  assign pin_in[3] = port5_in;

  // Single-cycle access phase: pready is always high.
  assign pready    = 1'b1;
  assign word_addr = paddr[9:2];
  assign wbyte     = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign sel_port  = port_index(word_addr);
  assign sel_mask  = port_mask(sel_port);

  // Misaligned or out-of-window addresses get an error response and no effect.
  assign addr_ok = is_mapped_addr(word_addr) && (paddr[1:0] == 2'b00) &&
                   (paddr[11:10] == 2'b00);

  assign wr_en   = psel && penable && pwrite && addr_ok && pstrb[0];
  assign pslverr = psel && penable && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    logic [1:0] bport;
    logic [2:0] bbit;
    bport = pwdata[1:0];
    bbit  = pwdata[GPIO_BOP_BIT_LSB +: 3];
    for (int i = 0; i < 4; i++)
    begin
      data_d[i] = data_q[i];
    end
    if (wr_en && is_data_addr(word_addr))
    begin
      data_d[sel_port] = wbyte & sel_mask;
    end
    else if (wr_en && (word_addr == GPIO_ADDR_BIT_OP) && bit_implemented(bport, bbit))
    begin
      // Only the addressed bit moves, so no read-back of the port is needed.
      data_d[bport][bbit] = pwdata[GPIO_BOP_VAL_BIT];
    end
    // The input-only pin has no output driver, so its latch bit stays clear.
    data_d[0][GPIO_INPUT_ONLY_BIT] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        data_q[i] <= GPIO_RESET_VAL;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        data_q[i] <= data_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up enables; the input-only pin has none, yet its bit stays set inside.

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      pullup_d[i] = pullup_q[i];
    end
    if (wr_en && is_pullup_addr(word_addr))
    begin
      pullup_d[sel_port] = wbyte & sel_mask;
    end
    pullup_d[0][GPIO_INPUT_ONLY_BIT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pullup_q[0] <= GPIO_RESET_VAL | GPIO_P0_FIXED_ONE;
      for (int i = 1; i < 4; i++)
      begin
        pullup_q[i] <= GPIO_RESET_VAL;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        pullup_q[i] <= pullup_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction bits; zero is input and one is output.

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      dir_d[i] = dir_q[i];
    end
    if (wr_en && is_dir_addr(word_addr))
    begin
      dir_d[sel_port] = wbyte & sel_mask;
    end
    dir_d[0][GPIO_INPUT_ONLY_BIT] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_q[0] <= GPIO_RESET_VAL | GPIO_P0_FIXED_ONE;
      for (int i = 1; i < 4; i++)
      begin
        dir_q[i] <= GPIO_RESET_VAL;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        dir_q[i] <= dir_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain enables; only the first two pins of port 1 have one.

  always_comb
  begin
    od_d = od_q;
    if (wr_en && (word_addr == GPIO_ADDR_OD_CTRL))
    begin
      od_d = wbyte & GPIO_MASK_OD;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      od_q <= GPIO_RESET_VAL;
    end
    else
    begin
      od_q <= od_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Read data: pin levels for data registers, direction readable too.
  // Pull-up and open-drain registers are write-only and read as zero.
  always_comb
  begin
    logic [7:0] rd;
    rd = 8'h00;
    case (word_addr)
      GPIO_ADDR_PORT0_DATA, GPIO_ADDR_PORT1_DATA, GPIO_ADDR_PORT2_DATA,
      GPIO_ADDR_PORT5_DATA:
      begin
        rd = pin_in[sel_port] & sel_mask;
        if (sel_port == 2'd0 && ext_reset_sel)
        begin
          rd[GPIO_INPUT_ONLY_BIT] = 1'b1;
        end
      end
      GPIO_ADDR_DIR_P0, GPIO_ADDR_DIR_P1, GPIO_ADDR_DIR_P2,
      GPIO_ADDR_DIR_P5:
        rd = dir_q[sel_port];
      default:
        rd = 8'h00;
    endcase
    prdata = (psel && !pwrite && addr_ok) ? {24'h000000, rd} : 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////

  // Open-drain overrides drive only; the direction bit is never touched,
  // so clearing the enable restores the earlier mode by itself.
  always_comb
  begin
    logic [7:0] oe1;
    logic [7:0] out1;
    oe1  = dir_q[1];
    out1 = data_q[1];
    for (int b = GPIO_OD_PIN_A_BIT; b <= GPIO_OD_PIN_B_BIT; b++)
    begin
      if (od_q[b])
      begin
        oe1[b]  = dir_q[1][b] & ~data_q[1][b];
        out1[b] = 1'b0;
      end
    end
    port1_oe  = oe1;
    port1_out = out1;
  end

  assign port0_out = data_q[0];
  assign port2_out = data_q[2];
  assign port5_out = data_q[3];
  // Pin 2 of port 0 never drives even though its direction bit reads one.
  assign port0_oe  = dir_q[0] & ~GPIO_P0_FIXED_ONE;
  assign port2_oe  = dir_q[2];
  assign port5_oe  = dir_q[3];
  assign port0_pullup = pullup_q[0] & ~GPIO_P0_FIXED_ONE;
  assign port1_pullup = pullup_q[1];
  assign port2_pullup = pullup_q[2];
  assign port5_pullup = pullup_q[3];

endmodule // gpio_ports
`default_nettype wire

/* File: shared/gpio_pkg.sv */
package gpio_pkg;

  // Register word indices on the APB (printed offsets, byte address is four times the index).
  localparam logic [7:0] GPIO_ADDR_PORT0_DATA = 8'hD0;
  localparam logic [7:0] GPIO_ADDR_PORT1_DATA = 8'hD1;
  localparam logic [7:0] GPIO_ADDR_PORT2_DATA = 8'hD2;
  localparam logic [7:0] GPIO_ADDR_PORT5_DATA = 8'hD5;
  localparam logic [7:0] GPIO_ADDR_PULLUP_P0  = 8'hE0;
  localparam logic [7:0] GPIO_ADDR_PULLUP_P1  = 8'hE1;
  localparam logic [7:0] GPIO_ADDR_PULLUP_P2  = 8'hE2;
  localparam logic [7:0] GPIO_ADDR_PULLUP_P5  = 8'hE5;
  localparam logic [7:0] GPIO_ADDR_OD_CTRL    = 8'hE9;
  localparam logic [7:0] GPIO_ADDR_DIR_P0     = 8'hB8;
  localparam logic [7:0] GPIO_ADDR_DIR_P1     = 8'hC1;
  localparam logic [7:0] GPIO_ADDR_DIR_P2     = 8'hC2;
  localparam logic [7:0] GPIO_ADDR_DIR_P5     = 8'hC5;
  localparam logic [7:0] GPIO_ADDR_BIT_OP     = 8'hF0;

  // Implemented pin masks per port.
  localparam logic [7:0] GPIO_MASK_P0 = 8'h1F;
  localparam logic [7:0] GPIO_MASK_P1 = 8'hFF;
  localparam logic [7:0] GPIO_MASK_P2 = 8'hFF;
  localparam logic [7:0] GPIO_MASK_P5 = 8'h1F;
  localparam logic [7:0] GPIO_MASK_OD = 8'h03;

  // Input-only pin of port 0 and its fixed control bits.
  localparam int unsigned GPIO_INPUT_ONLY_BIT = 2;
  localparam logic [7:0]  GPIO_P0_FIXED_ONE   = 8'h04;

  // Open-drain bit positions.
  localparam int unsigned GPIO_OD_PIN_A_BIT = 0;
  localparam int unsigned GPIO_OD_PIN_B_BIT = 1;

  // Reset value of every control register; port 0 pull-up and direction add the fixed bit.
  localparam logic [7:0] GPIO_RESET_VAL = 8'h00;

  // Bit operation word fields: [1:0] port select, [4:2] bit, [8] value.
  localparam int unsigned GPIO_BOP_BIT_LSB = 2;
  localparam int unsigned GPIO_BOP_VAL_BIT = 8;

endpackage

/* File: verif/gpio_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_model #(parameter logic [7:0] RES = 8'h00)
(
  // Pad controls and far-side drive.
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] ext,
  // Resolved line.
  output logic [7:0]      pin
);
  // A released line rises on a pull-up, else follows the far side.
  assign pin = (oe & out) | (~oe & (RES | pu | ext));
endmodule // gpio_pin_model
`default_nettype wire

/* File: verif/gpio_ports_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_chk
  import gpio_pkg::*;
(
  // Register bus.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // Pins and pads.
  input wire logic        ext_reset_sel,
  input wire logic [7:0]  port2_in,
  input wire logic [7:0]  port1_out,
  input wire logic [7:0]  port0_pullup,
  input wire logic [7:0]  port1_pullup,
  input wire logic [7:0]  port5_pullup
);
  logic [1:0] od_q;
  logic [1:0] od_d;
  always_comb
  begin
    od_d = od_q;
    if (psel && penable && pwrite && pstrb[0] && paddr == 12'h3A4)
      od_d = pwdata[1:0];
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      od_q <= 2'h0;
    else
      od_q <= od_d;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_acc(a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence rd_acc(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  chk_pu_write: assert property (wr_acc(12'h384) |=> port1_pullup == $past(pwdata[7:0]))
    else $error("pull-up write lost");
  chk_pu_reset: assert property ($rose(presetn) |-> port1_pullup == 8'h00)
    else $error("pull-up not cleared");
  chk_p0_pu_none: assert property (port0_pullup[2] == 1'b0)
    else $error("input-only pin pulled up");
  chk_od_sink: assert property ((od_q & port1_out[1:0]) == 2'h0)
    else $error("open-drain pin drives high");
  chk_data_write: assert property (wr_acc(12'h344) |=> port1_out[7:2] == $past(pwdata[7:2]))
    else $error("latch write lost");
  chk_rd_pins: assert property (rd_acc(12'h348) |-> prdata == {24'h0, port2_in})
    else $error("pin read wrong");
  chk_ext_rst: assert property ((rd_acc(12'h340) ##0 ext_reset_sel) |-> prdata[2])
    else $error("reset pin bit not one");
  chk_unimpl_bits: assert property ((port0_pullup[7:5] | port5_pullup[7:5]) == 3'h0)
    else $error("unimplemented bit set");
  chk_od_rd_zero: assert property (rd_acc(12'h3A4) |-> prdata == 32'h0)
    else $error("write-only register readable");
endmodule // gpio_ports_chk
`default_nettype wire

/* File: verif/gpio_pullup_opendrain_ports_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_pullup_opendrain_ports_tb_top
  import gpio_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ers = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, b;
  logic [3:0]  pstrb = 4'hF;
  wire logic   pready, pslverr;
  wire logic [31:0] prdata;
  logic [7:0]  o[4], e[4], u[4], pin[4], ext[4] = '{default: 8'h00};
  logic [7:0]  lat[4] = '{default: 8'h00}, dir[4] = '{default: 8'h00};
  logic [7:0]  pu[4] = '{default: 8'h00}, od = 8'h00;
  localparam logic [7:0] RM[4] = '{GPIO_MASK_P0, GPIO_MASK_P1, GPIO_MASK_P2, GPIO_MASK_P5};
  localparam int PO[4] = '{0, 1, 2, 5};
  int          miscompares = 0, compares = 0, cyc = 0;
  integer      seed = 32'h234F2883;
  gpio_ports DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .pslverr, .prdata, .ext_reset_sel(ers), .port0_in(pin[0]), .port1_in(pin[1]),
    .port2_in(pin[2]), .port5_in(pin[3]), .port0_out(o[0]), .port1_out(o[1]), .port2_out(o[2]),
    .port5_out(o[3]), .port0_oe(e[0]), .port1_oe(e[1]), .port2_oe(e[2]), .port5_oe(e[3]),
    .port0_pullup(u[0]), .port1_pullup(u[1]), .port2_pullup(u[2]), .port5_pullup(u[3]));
  // Port 1 pins 0 and 1 carry the board's external pull-up resistors.
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    gpio_pin_model #(.RES(i == 1 ? 8'h03 : 8'h00)) m (.oe(e[i]), .out(o[i]), .pu(u[i]),
      .ext(ext[i]), .pin(pin[i]));
  end
  always #2 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      miscompares++;
      wrap_up;
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Kind -1 is direction, 0 is data, 1 is pull-up.
  function automatic logic [11:0] ad(input int k, input int p);
    if (k == -1 && p == 0)
      return 12'h2E0;
    return 12'(32'h340 + 32'h40 * k + 4 * PO[p]);
  endfunction
  task wr(input int k, input int p, input logic [7:0] v);
    apb(1'b1, ad(k, p), {24'h0, v});
    if (k == 0)
      lat[p] = v;
    else if (k < 0)
      dir[p] = v;
    else
      pu[p] = v;
  endtask
  task check_all;
    logic [7:0] m, xo, xe, xp;
    for (int p = 0; p < 4; p++)
    begin
      ext[p] <= 8'($random(seed));
      m = RM[p] & ~(p == 0 ? GPIO_P0_FIXED_ONE : 8'h00);
      xe = dir[p] & m;
      xo = lat[p] & m;
      if (p == 1)
      begin
        xe = xe & ~(od & xo);
        xo = xo & ~od;
      end
      chk("out", o[p], xo);
      chk("oe", e[p], xe);
      chk("pullup", u[p], pu[p] & m);
      apb(1'b0, ad(0, p), 32'h0);
      xp = ((xe & xo) | (~xe & ((p == 1 ? 8'h03 : 8'h00) | (pu[p] & m) | ext[p]))) & RM[p];
      chk("pins", rd, {24'h0, xp | (p == 0 && ers ? 8'h04 : 8'h00)});
      chk("slverr ok", {31'h0, err}, 32'h0);
      apb(1'b0, ad(-1, p), 32'h0);
      chk("dir", rd, {24'h0, (dir[p] & m) | (p == 0 ? 8'h04 : 8'h00)});
      apb(1'b0, ad(1, p), 32'h0);
      chk("pullup read", rd, 32'h0);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_all;
    $display("test reset done");
    repeat (3)
    begin
      for (int p = 0; p < 4; p++)
      begin
        wr(0, p, 8'($random(seed)));
        wr(-1, p, 8'($random(seed)));
        wr(1, p, 8'($random(seed)));
      end
      check_all;
    end
    $display("test byte writes done");
    repeat (8)
    begin
      b = 32'($random(seed)) & 32'h11F;
      apb(1'b1, 12'h3C0, b);
      lat[b[1:0]][b[4:2]] = b[8];
      check_all;
    end
    $display("test bit ops done");
    wr(-1, 1, 8'h03);
    wr(0, 1, 8'h01);
    od = 8'h03;
    apb(1'b1, 12'h3A4, 32'h3);
    check_all;
    apb(1'b0, 12'h3A4, 32'h0);
    chk("od read", rd, 32'h0);
    wr(0, 1, 8'h02);
    check_all;
    od = 8'h00;
    apb(1'b1, 12'h3A4, 32'h0);
    check_all;
    $display("test open drain done");
    ers <= 1'b1;
    check_all;
    apb(1'b0, 12'h341, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    chk("bad read", rd, 32'h0);
    pstrb <= 4'hE;
    apb(1'b1, ad(0, 1), 32'hFF);
    pstrb <= 4'hF;
    chk("strobe slverr", {31'h0, err}, 32'h0);
    check_all;
    $display("test refusals done");
    wrap_up;
  end
endmodule // gpio_pullup_opendrain_ports_tb_top
bind gpio_ports gpio_ports_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .ext_reset_sel, .port2_in, .port1_out, .port0_pullup,
  .port1_pullup, .port5_pullup);
`default_nettype wire
